// file: rtl/mono_video_format_selector.sv
// Video format, mode, rate and pixel coding selector with AHB-Lite registers
//
// Summary of operation
// - Format 0 mode 1: 320x240 YUV, five rates
// - Format 1 modes 2,5,6,7 with listed rates
// - Format 2 modes 2,5,6,7 with listed rates
// - YUV output carries luminance only, neutral chroma
// - 16-bit gray: 12 data bits, upper zero
// - 16-bit pixels sent low byte first
// - Standard modes read a centered sensor region
// - Format 7 mode 0 enables area of interest
// - Custom mode rate follows bytes per packet
// - Maximum payload reported; at maximum, top rate
// - Reset: full sensor area, 4096-byte payload
// - Custom mode: one packet per 125 us cycle
// - Custom mode ignores frame rate register writes
// - Custom mode: only 8/16-bit gray codings
// - Custom 16-bit gray: 12 bits right-aligned
// - 16-bit full frame never above 8.15 fps
//
// The register offsets and the AHB-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
module mono_video_format_selector #(
  parameter int unsigned SENSOR_W = vfs_pkg::SENSOR_W_DEF,
  parameter int unsigned SENSOR_H = vfs_pkg::SENSOR_H_DEF,
  parameter int unsigned BUS_CYCLE_CLKS = vfs_pkg::BUS_CYCLE_CLKS,
  parameter int unsigned FRAME_CLKS_TOP = vfs_pkg::FRAME_CLKS_TOP
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic pix_valid,
  input wire logic [vfs_pkg::PIX_W-1:0] pix_data,
  output logic pix_ready,
  output logic byte_valid,
  output logic [7:0] byte_data,
  output logic byte_sof,
  output logic frame_start,
  output logic [vfs_pkg::DIM_W-1:0] roi_left,
  output logic [vfs_pkg::DIM_W-1:0] roi_top,
  output logic [vfs_pkg::DIM_W-1:0] roi_width,
  output logic [vfs_pkg::DIM_W-1:0] roi_height
);
  import vfs_pkg::*;

  localparam int unsigned BUS_CNT_W = $clog2(BUS_CYCLE_CLKS);
  localparam logic [11:0] SENSOR_W12 = 12'(SENSOR_W);
  localparam logic [11:0] SENSOR_H12 = 12'(SENSOR_H);

  typedef enum {CALC_IDLE, CALC_MAX, CALC_PPF_GO, CALC_PPF} calc_state_t;

  // Supported standard modes
  function automatic mode_info_t mode_info(input logic [2:0] f, input logic [2:0] m);
    mode_info_t i;
    i = '{1'b0, PK_MONO8, 11'h000, 11'h000, 3'h0, 3'h0};
    unique case ({f, m})
      {3'h0, 3'h1}: i = '{1'b1, PK_YUV, 11'd320, 11'd240, 3'h0, 3'h4};
      {3'h1, 3'h2}: i = '{1'b1, PK_MONO8, 11'd800, 11'd600, 3'h2, 3'h3};
      {3'h1, 3'h5}: i = '{1'b1, PK_MONO8, 11'd1024, 11'd768, 3'h1, 3'h3};
      {3'h1, 3'h6}: i = '{1'b1, PK_MONO16, 11'd800, 11'd600, 3'h1, 3'h3};
      {3'h1, 3'h7}: i = '{1'b1, PK_MONO16, 11'd1024, 11'd768, 3'h1, 3'h3};
      {3'h2, 3'h2}: i = '{1'b1, PK_MONO8, 11'd1280, 11'd960, 3'h0, 3'h3};
      {3'h2, 3'h5}: i = '{1'b1, PK_MONO8, 11'd1600, 11'd1200, 3'h0, 3'h2};
      {3'h2, 3'h6}: i = '{1'b1, PK_MONO16, 11'd1280, 11'd960, 3'h0, 3'h2};
      {3'h2, 3'h7}: i = '{1'b1, PK_MONO16, 11'd1600, 11'd1200, 3'h0, 3'h2};
      default: i.ok = 1'b0;
    endcase
    return i;
  endfunction

  function automatic logic rate_fits(input mode_info_t i, input logic [2:0] r);
    return i.ok && (r >= i.rmin) && (r <= i.rmax);
  endfunction

  function automatic logic span_fits(input logic [DIM_W-1:0] p, input logic [DIM_W-1:0] s,
                                     input logic [11:0] lim);
    return (s != '0) && (({1'b0, p} + {1'b0, s}) <= lim);
  endfunction

  // Bus slave state
  logic ap;
  logic wr_pend_q;
  logic rd_pend_q;
  logic [ADDR_W-1:0] addr_q;
  logic [31:0] rd_word;
  logic wr_ok;

  // Configuration registers
  logic [2:0] fmt_q;
  logic [2:0] mode_q;
  logic [2:0] rate_q;
  logic [7:0] coding_q;
  logic [DIM_W-1:0] aoi_left_q;
  logic [DIM_W-1:0] aoi_top_q;
  logic [DIM_W-1:0] aoi_w_q;
  logic [DIM_W-1:0] aoi_h_q;
  logic [BPP_W-1:0] bpp_q;
  logic enable_q;
  logic reject_q;
  logic cfg_dirty_q;

  // Derived selection
  logic custom;
  mode_info_t cur_info;
  pix_kind_t kind;
  logic two_byte;
  logic [DIM_W-1:0] cur_w;
  logic [DIM_W-1:0] cur_h;
  logic [FB_W-1:0] pix_count;
  logic [FB_W-1:0] frame_bytes;
  logic [BPP_W-1:0] eff_bpp;

  // Payload calculation
  calc_state_t calc_q;
  logic [BPP_W-1:0] max_bpp_q;
  logic [FB_W-1:0] ppf_q;
  logic div_start;
  logic [FB_W-1:0] div_den;
  logic div_busy;
  logic div_done;
  logic [FB_W-1:0] div_quot;
  logic div_rem_nz;

  // Frame timing and pixel path
  logic [BUS_CNT_W-1:0] bus_cnt_q;
  logic bus_tick;
  logic [31:0] fr_cnt_q;
  logic [31:0] frame_period;
  logic [FB_W-1:0] pkt_cnt_q;
  logic frame_go;
  logic accept;
  logic [FB_W-1:0] pix_left_q;
  logic [FB_W-1:0] pix_left_d;
  logic [BPP_W:0] pkt_bytes_q;
  logic [BPP_W:0] pkt_bytes_d;
  logic [BPP_W:0] step;
  logic room;
  logic phase_q;
  logic [7:0] hold_q;
  logic sof_pend_q;

  // Bus slave: writes take no wait state, reads take one
  assign ap = hsel && htrans[1] && hready;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      addr_q <= '0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      wr_pend_q <= ap && hwrite;
      rd_pend_q <= ap && !hwrite;
      if (ap) begin
        addr_q <= {haddr[ADDR_W-1:2], 2'b00};
      end
      hreadyout <= !(ap && !hwrite);
      hresp <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      hrdata <= '0;
    end else if (rd_pend_q) begin
      hrdata <= rd_word;
    end
  end

  always_comb begin
    rd_word = '0;
    unique case (addr_q)
      OFS_FORMAT: rd_word = {25'h0, mode_q, 1'b0, fmt_q};
      OFS_RATE: rd_word = {29'h0, rate_q};
      OFS_CODING: rd_word = {24'h0, coding_q};
      OFS_AOI_POS: rd_word = {5'h0, aoi_left_q, 5'h0, aoi_top_q};
      OFS_AOI_SIZE: rd_word = {5'h0, aoi_w_q, 5'h0, aoi_h_q};
      OFS_BPP: rd_word = {19'h0, bpp_q};
      OFS_MAX_BPP: rd_word = {19'h0, max_bpp_q};
      OFS_STATUS: begin
        rd_word[ST_REJECT] = reject_q;
        rd_word[ST_BUSY] = (calc_q != CALC_IDLE) || cfg_dirty_q;
        rd_word[ST_PPF_OVER] = (ppf_q > FB_W'(MAX_PKT_PER_FRAME));
        rd_word[ST_CUSTOM] = custom;
      end
      OFS_PPF: rd_word = {8'h00, ppf_q};
      OFS_CONTROL: rd_word = {31'h0, enable_q};
      default: rd_word = '0;
    endcase
  end

  // Write check: unsupported values are refused and nothing changes
  always_comb begin
    wr_ok = 1'b0;
    unique case (addr_q)
      OFS_FORMAT: wr_ok = ((hwdata[FMT_LSB +: 3] == FMT_CUSTOM) && (hwdata[MODE_LSB +: 3] == MODE_CUSTOM))
                          || rate_fits(mode_info(hwdata[FMT_LSB +: 3], hwdata[MODE_LSB +: 3]), rate_q);
      OFS_RATE: wr_ok = custom || rate_fits(cur_info, hwdata[2:0]);
      OFS_CODING: wr_ok = (hwdata[7:0] == CODE_MONO8) || (hwdata[7:0] == CODE_MONO16);
      OFS_AOI_POS: wr_ok = span_fits(hwdata[HI_LSB +: DIM_W], aoi_w_q, SENSOR_W12)
                           && span_fits(hwdata[DIM_W-1:0], aoi_h_q, SENSOR_H12);
      OFS_AOI_SIZE: wr_ok = span_fits(aoi_left_q, hwdata[HI_LSB +: DIM_W], SENSOR_W12)
                            && span_fits(aoi_top_q, hwdata[DIM_W-1:0], SENSOR_H12);
      OFS_BPP: wr_ok = (hwdata[BPP_W-1:0] != '0) && (hwdata[BPP_W-1:0] <= MAX_BPP) && (hwdata[31:BPP_W] == '0);
      OFS_CONTROL: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      fmt_q <= RST_FMT;
      mode_q <= RST_MODE;
      rate_q <= RST_RATE;
      coding_q <= CODE_MONO8;
      aoi_left_q <= '0;
      aoi_top_q <= '0;
      aoi_w_q <= DIM_W'(SENSOR_W);
      aoi_h_q <= DIM_W'(SENSOR_H);
      bpp_q <= RST_BPP;
      enable_q <= 1'b0;
    end else if (wr_pend_q && wr_ok) begin
      unique case (addr_q)
        OFS_FORMAT: begin
          fmt_q <= hwdata[FMT_LSB +: 3];
          mode_q <= hwdata[MODE_LSB +: 3];
        end
        OFS_RATE: begin
          if (!custom) begin
            rate_q <= hwdata[2:0];
          end
        end
        OFS_CODING: coding_q <= hwdata[7:0];
        OFS_AOI_POS: begin
          aoi_left_q <= hwdata[HI_LSB +: DIM_W];
          aoi_top_q <= hwdata[DIM_W-1:0];
        end
        OFS_AOI_SIZE: begin
          aoi_w_q <= hwdata[HI_LSB +: DIM_W];
          aoi_h_q <= hwdata[DIM_W-1:0];
        end
        OFS_BPP: bpp_q <= hwdata[BPP_W-1:0];
        OFS_CONTROL: enable_q <= hwdata[0];
        default: enable_q <= enable_q;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      reject_q <= 1'b0;
    end else if (wr_pend_q) begin
      reject_q <= !wr_ok;
    end
  end

  // A new accepted write outranks the clear at calculation start
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cfg_dirty_q <= 1'b1;
    end else if (wr_pend_q && wr_ok) begin
      cfg_dirty_q <= 1'b1;
    end else if (calc_q == CALC_IDLE && !div_busy) begin
      cfg_dirty_q <= 1'b0;
    end
  end

  // Active selection
  assign custom = (fmt_q == FMT_CUSTOM);
  assign cur_info = mode_info(fmt_q, mode_q);
  assign cur_w = custom ? aoi_w_q : cur_info.w;
  assign cur_h = custom ? aoi_h_q : cur_info.h;
  assign kind = custom ? ((coding_q == CODE_MONO16) ? PK_MONO16 : PK_MONO8) : cur_info.kind;
  assign two_byte = (kind != PK_MONO8);
  assign pix_count = FB_W'(cur_w) * FB_W'(cur_h);
  assign frame_bytes = two_byte ? {pix_count[FB_W-2:0], 1'b0} : pix_count;
  assign eff_bpp = (bpp_q > max_bpp_q) ? max_bpp_q : bpp_q;

  // Payload limits: maximum payload, then packets per frame
  assign div_start = (calc_q == CALC_IDLE && cfg_dirty_q && !div_busy) || (calc_q == CALC_PPF_GO);
  assign div_den = (calc_q == CALC_IDLE) ? FB_W'(MIN_PKT_PER_FRAME) : FB_W'(eff_bpp);

  udiv_seq #(
    .NUM_W(FB_W),
    .DEN_W(FB_W)
  ) payload_div (
    .ref_clk(ref_clk),
    .rst(rst),
    .start(div_start),
    .num(frame_bytes),
    .den(div_den),
    .busy(div_busy),
    .done(div_done),
    .quot(div_quot),
    .rem_nz(div_rem_nz)
  );

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      calc_q <= CALC_IDLE;
      max_bpp_q <= MAX_BPP;
      ppf_q <= '0;
    end else begin
      unique case (calc_q)
        CALC_IDLE: begin
          if (div_start) begin
            calc_q <= CALC_MAX;
          end
        end
        CALC_MAX: begin
          if (div_done) begin
            // Floor keeps packets per frame at or above the top-rate count
            if (div_quot == '0) begin
              max_bpp_q <= BPP_W'(1);
            end else if (div_quot > FB_W'(MAX_BPP)) begin
              max_bpp_q <= MAX_BPP;
            end else begin
              max_bpp_q <= div_quot[BPP_W-1:0];
            end
            calc_q <= CALC_PPF_GO;
          end
        end
        CALC_PPF_GO: calc_q <= CALC_PPF;
        CALC_PPF: begin
          if (div_done) begin
            ppf_q <= div_quot + FB_W'(div_rem_nz);
            calc_q <= CALC_IDLE;
          end
        end
      endcase
    end
  end

  // Isochronous cycle and frame timing
  assign bus_tick = (bus_cnt_q == BUS_CNT_W'(BUS_CYCLE_CLKS - 1));
  assign frame_period = FRAME_CLKS_TOP << (RATE_TOP - rate_q);

  always_comb begin
    frame_go = 1'b0;
    if (enable_q) begin
      if (custom) begin
        frame_go = bus_tick && (FB_W'(pkt_cnt_q) + FB_W'(1) >= ppf_q) && (ppf_q != '0);
      end else begin
        frame_go = (fr_cnt_q + 32'h1 >= frame_period);
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      bus_cnt_q <= '0;
    end else if (bus_tick) begin
      bus_cnt_q <= '0;
    end else begin
      bus_cnt_q <= bus_cnt_q + 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst || !enable_q || frame_go || custom) begin
      fr_cnt_q <= '0;
    end else begin
      fr_cnt_q <= fr_cnt_q + 32'h1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst || !enable_q || frame_go || !custom) begin
      pkt_cnt_q <= '0;
    end else if (bus_tick) begin
      pkt_cnt_q <= pkt_cnt_q + FB_W'(1);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      frame_start <= 1'b0;
    end else begin
      frame_start <= frame_go;
    end
  end

  // Readout region
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      roi_left <= '0;
      roi_top <= '0;
      roi_width <= DIM_W'(SENSOR_W);
      roi_height <= DIM_W'(SENSOR_H);
    end else begin
      roi_left <= custom ? aoi_left_q : DIM_W'((SENSOR_W12 - {1'b0, cur_w}) >> 1);
      roi_top <= custom ? aoi_top_q : DIM_W'((SENSOR_H12 - {1'b0, cur_h}) >> 1);
      roi_width <= cur_w;
      roi_height <= cur_h;
    end
  end

  // Pixel intake, paced per isochronous cycle in custom mode
  assign accept = pix_valid && pix_ready;
  assign step = two_byte ? (BPP_W+1)'(2) : (BPP_W+1)'(1);
  assign pkt_bytes_d = (bus_tick ? '0 : pkt_bytes_q) + (accept ? step : '0);
  assign room = !custom || ((pkt_bytes_d + step) <= {1'b0, eff_bpp});
  assign pix_left_d = frame_go ? pix_count : (pix_left_q - FB_W'(accept));

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pix_left_q <= '0;
      pkt_bytes_q <= '0;
      pix_ready <= 1'b0;
      phase_q <= 1'b0;
    end else begin
      pix_left_q <= pix_left_d;
      pkt_bytes_q <= pkt_bytes_d;
      phase_q <= accept && two_byte;
      pix_ready <= enable_q && !(accept && two_byte) && (pix_left_d != '0) && room;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sof_pend_q <= 1'b0;
    end else if (frame_go) begin
      sof_pend_q <= 1'b1;
    end else if (accept) begin
      sof_pend_q <= 1'b0;
    end
  end

  // Byte stream out
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      byte_valid <= 1'b0;
      byte_data <= '0;
      byte_sof <= 1'b0;
      hold_q <= '0;
    end else if (accept) begin
      byte_valid <= 1'b1;
      byte_sof <= sof_pend_q;
      unique case (kind)
        PK_MONO8: byte_data <= pix_data[PIX_W-1:PIX_W-8];
        PK_MONO16: begin
          byte_data <= pix_data[7:0];
          hold_q <= {4'h0, pix_data[PIX_W-1:8]};
        end
        PK_YUV: begin
          byte_data <= YUV_CHROMA_NEUTRAL;
          hold_q <= pix_data[PIX_W-1:PIX_W-8];
        end
        default: byte_data <= '0;
      endcase
    end else if (phase_q) begin
      byte_valid <= 1'b1;
      byte_sof <= 1'b0;
      byte_data <= hold_q;
    end else begin
      byte_valid <= 1'b0;
      byte_sof <= 1'b0;
    end
  end
endmodule // mono_video_format_selector

// file: inc/vfs_pkg.sv
// Constants and types for the monochrome video format selector
package vfs_pkg;
  // Clock and bus timing
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned CLK_HZ = CLK_MHZ * 1000000;
  localparam int unsigned BUS_CYCLE_US = 125;
  localparam int unsigned BUS_CYCLE_CLKS = BUS_CYCLE_US * CLK_MHZ;
  localparam int unsigned TOP_STD_FPS = 30;
  localparam int unsigned FRAME_CLKS_TOP = CLK_HZ / TOP_STD_FPS;
  // Top custom rate 8.15 fps, in hundredths of a frame per second
  localparam int unsigned CUSTOM_TOP_CFPS = 815;
  localparam int unsigned PKT_SCALE = 100000000;
  localparam int unsigned MIN_PKT_PER_FRAME =
    (PKT_SCALE + CUSTOM_TOP_CFPS * BUS_CYCLE_US - 1) / (CUSTOM_TOP_CFPS * BUS_CYCLE_US);
  localparam int unsigned MAX_PKT_PER_FRAME = 4095;

  // Widths and sensor geometry
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DIM_W = 11;
  localparam int unsigned BPP_W = 13;
  localparam int unsigned FB_W = 24;
  localparam int unsigned PIX_W = 12;
  localparam int unsigned SENSOR_W_DEF = 1600;
  localparam int unsigned SENSOR_H_DEF = 1200;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_FORMAT = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_RATE = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_CODING = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_AOI_POS = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_AOI_SIZE = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_BPP = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_MAX_BPP = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_PPF = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_CONTROL = 8'h24;

  // Field positions
  localparam int unsigned FMT_LSB = 0;
  localparam int unsigned MODE_LSB = 4;
  localparam int unsigned HI_LSB = 16;
  localparam int unsigned ST_REJECT = 0;
  localparam int unsigned ST_BUSY = 1;
  localparam int unsigned ST_PPF_OVER = 2;
  localparam int unsigned ST_CUSTOM = 3;

  // Selector codes
  localparam logic [2:0] FMT_CUSTOM = 3'h7;
  localparam logic [2:0] MODE_CUSTOM = 3'h0;
  localparam logic [2:0] RATE_TOP = 3'h4;
  localparam logic [7:0] CODE_MONO8 = 8'h00;
  localparam logic [7:0] CODE_MONO16 = 8'h05;
  localparam logic [7:0] YUV_CHROMA_NEUTRAL = 8'h80;

  // Reset values
  localparam logic [2:0] RST_FMT = FMT_CUSTOM;
  localparam logic [2:0] RST_MODE = MODE_CUSTOM;
  localparam logic [2:0] RST_RATE = 3'h2;
  localparam logic [BPP_W-1:0] RST_BPP = 13'h1000;
  localparam logic [BPP_W-1:0] MAX_BPP = 13'h1000;

  typedef enum logic [1:0] {PK_MONO8, PK_MONO16, PK_YUV} pix_kind_t;

  typedef struct packed {
    logic ok;
    pix_kind_t kind;
    logic [DIM_W-1:0] w;
    logic [DIM_W-1:0] h;
    logic [2:0] rmin;
    logic [2:0] rmax;
  } mode_info_t;
endpackage

// file: rtl/udiv_seq.sv
// Sequential restoring divider, quotient and nonzero-remainder flag
`timescale 1ns/1ps
module udiv_seq #(
  parameter int unsigned NUM_W = 24,
  parameter int unsigned DEN_W = 24
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic start,
  input wire logic [NUM_W-1:0] num,
  input wire logic [DEN_W-1:0] den,
  output logic busy,
  output logic done,
  output logic [NUM_W-1:0] quot,
  output logic rem_nz
);
  localparam int unsigned CNT_W = $clog2(NUM_W + 1);

  logic [DEN_W-1:0] rem_q;
  logic [DEN_W-1:0] den_q;
  logic [CNT_W-1:0] cnt_q;
  logic [DEN_W:0] shifted;
  logic [DEN_W+1:0] diff;

  assign shifted = {rem_q, quot[NUM_W-1]};
  assign diff = {1'b0, shifted} - {2'b00, den_q};
  assign rem_nz = (rem_q != '0);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      busy <= 1'b0;
      done <= 1'b0;
      quot <= '0;
      rem_q <= '0;
      den_q <= '0;
      cnt_q <= '0;
    end else begin
      done <= 1'b0;
      if (start && !busy) begin
        quot <= num;
        rem_q <= '0;
        den_q <= den;
        cnt_q <= CNT_W'(NUM_W);
        busy <= 1'b1;
      end else if (busy) begin
        if (!diff[DEN_W+1]) begin
          rem_q <= diff[DEN_W-1:0];
          quot <= {quot[NUM_W-2:0], 1'b1};
        end else begin
          rem_q <= shifted[DEN_W-1:0];
          quot <= {quot[NUM_W-2:0], 1'b0};
        end
        cnt_q <= cnt_q - 1'b1;
        if (cnt_q == CNT_W'(1)) begin
          busy <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end
endmodule // udiv_seq

// file: tb/mono_video_format_selector_props.sv
// Port checker for the video format selector
`timescale 1ns/1ps
module mono_video_format_selector_props #(
  parameter int unsigned SENSOR_W = vfs_pkg::SENSOR_W_DEF
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic hresp,
  input wire logic pix_valid,
  input wire logic [vfs_pkg::PIX_W-1:0] pix_data,
  input wire logic pix_ready,
  input wire logic byte_valid,
  input wire logic [7:0] byte_data,
  input wire logic frame_start,
  input wire logic [vfs_pkg::DIM_W-1:0] roi_width
);
  import vfs_pkg::*;
  logic [PIX_W-1:0] px_q;
  wire go = hsel && htrans[1] && hready;
  wire take = pix_valid && pix_ready;
  // Last pixel taken, for the byte pair check
  always_ff @(posedge ref_clk) begin
    if (take) begin
      px_q <= pix_data;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence s_take;
    take;
  endsequence
  sequence s_pair;
    s_take ##1 (byte_valid && !pix_ready) ##1 byte_valid;
  endsequence
  a_resp_okay: assert property (!hresp) else $error("bad hresp");
  a_read_wait: assert property (go && !hwrite |=> !hreadyout ##1 hreadyout) else $error("read wait");
  a_write_now: assert property (go && hwrite |=> hreadyout) else $error("write wait");
  a_data_hold: assert property (!$stable(hrdata) |-> !$past(hreadyout)) else $error("hrdata moved");
  a_byte_next: assert property (s_take |=> byte_valid) else $error("no byte");
  a_pair_code: assert property (s_pair |->
    ($past(byte_data) == px_q[7:0] && byte_data == {4'h0, px_q[11:8]}) ||
    ($past(byte_data) == 8'h80 && byte_data == px_q[11:4])) else $error("pixel bytes");
  a_frame_pulse: assert property (frame_start |=> !frame_start) else $error("frame pulse");
  a_rst_state: assert property (disable iff (1'b0) rst |=> hreadyout && roi_width == SENSOR_W)
    else $error("reset state");
endmodule // mono_video_format_selector_props

bind mono_video_format_selector mono_video_format_selector_props #(.SENSOR_W(SENSOR_W)) i_props (
  .ref_clk(ref_clk), .rst(rst), .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .pix_valid(pix_valid), .pix_data(pix_data),
  .pix_ready(pix_ready), .byte_valid(byte_valid), .byte_data(byte_data), .frame_start(frame_start),
  .roi_width(roi_width));

// file: tb/pixel_source.sv
// Sensor pixel source model for the stream input
`timescale 1ns/1ps
module pixel_source (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic slow,
  input wire logic pix_ready,
  output logic pix_valid,
  output logic [vfs_pkg::PIX_W-1:0] pix_data
);
  import vfs_pkg::*;
  // Pixel holds until taken; slow inserts a gap
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pix_valid <= 1'b0;
      pix_data <= 12'hA5C;
    end else if (pix_valid && pix_ready) begin
      pix_valid <= !slow;
      pix_data <= pix_data + 12'h35B;
    end else begin
      pix_valid <= 1'b1;
    end
  end
endmodule // pixel_source

// file: tb/test_mono_video_format_selector.sv
// Self-checking bench for the video format selector
`timescale 1ns/1ps
module test_mono_video_format_selector;
  import vfs_pkg::*;
  logic ref_clk, rst, hsel, hwrite, hresp, hreadyout, slow, sof;
  logic pix_valid, pix_ready, byte_valid, frame_start;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [PIX_W-1:0] pix_data;
  logic [7:0] byte_data;
  logic [DIM_W-1:0] roi_left, roi_top, roi_width, roi_height;
  logic [7:0] fv [8] = '{8'h21, 8'h51, 8'h61, 8'h71, 8'h22, 8'h52, 8'h62, 8'h72};
  logic [DIM_W-1:0] wv [8] = '{11'h320, 11'h400, 11'h320, 11'h400, 11'h500, 11'h640, 11'h500, 11'h640};
  int err_count = 0;
  int checks = 0;

  mono_video_format_selector #(.BUS_CYCLE_CLKS(4), .FRAME_CLKS_TOP(200)) i_dut (
    .ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .pix_valid(pix_valid), .pix_data(pix_data), .pix_ready(pix_ready),
    .byte_valid(byte_valid), .byte_data(byte_data), .byte_sof(sof), .frame_start(frame_start),
    .roi_left(roi_left), .roi_top(roi_top), .roi_width(roi_width), .roi_height(roi_height));
  pixel_source i_src (.ref_clk(ref_clk), .rst(rst), .slow(slow), .pix_ready(pix_ready),
    .pix_valid(pix_valid), .pix_data(pix_data));

  task automatic end_sim;
    if (err_count == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge ref_clk); while (!hreadyout);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge ref_clk); while (!hreadyout);
    r = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    bus(a, 1'b0, 32'h0);
    chk(r, exp);
  endtask
  // Poll until the payload calculation is idle
  task automatic wait_calc;
    r = 32'h2;
    for (int i = 0; i < 80 && r[1]; i++) begin
      bus(OFS_STATUS, 1'b0, 32'h0);
    end
  endtask
  // Kind 0 mono8, 1 mono16, 2 luminance-only YUV
  task automatic px_chk(input logic [1:0] k);
    logic [PIX_W-1:0] p;
    do @(negedge ref_clk); while (!(pix_valid && pix_ready));
    p = pix_data;
    @(negedge ref_clk);
    chk({24'h0, k == 2'h0 ? p[11:4] : k == 2'h1 ? p[7:0] : 8'h80}, {24'h0, byte_data});
    if (k == 2'h2) chk({31'h0, sof}, 32'h1);
    if (k != 2'h0) begin
      @(negedge ref_clk);
      chk({24'h0, k == 2'h1 ? {4'h0, p[11:8]} : p[11:4]}, {24'h0, byte_data});
    end
    @(posedge ref_clk);
  endtask
  // Cycles between the second and third frame starts
  task automatic per(input int exp);
    int n;
    repeat (3) begin
      n = 0;
      do begin
        @(negedge ref_clk);
        n++;
      end while (!frame_start && n < 9000);
    end
    chk(n, exp);
    @(posedge ref_clk);
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (60000) @(posedge ref_clk);
    err_count++;
    end_sim;
  end
  initial begin
    rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    slow = 1'b0;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    rd(OFS_FORMAT, 32'h7);
    rd(OFS_BPP, 32'h1000);
    chk({10'h0, roi_width, roi_height}, {10'h0, 11'h640, 11'h4B0});
    wait_calc;
    rd(OFS_STATUS, 32'h8);
    rd(OFS_MAX_BPP, 32'h7A3);
    rd(OFS_PPF, 32'h3D7);
    wr(OFS_BPP, 32'h3E8);
    wait_calc;
    rd(OFS_PPF, 32'h780);
    wr(OFS_RATE, 32'h0);
    rd(OFS_RATE, 32'h2);
    wr(OFS_CODING, 32'h1);
    wait_calc;
    rd(OFS_STATUS, 32'h9);
    rd(OFS_CODING, 32'h0);
    wr(OFS_CODING, 32'h5);
    wait_calc;
    rd(OFS_MAX_BPP, 32'hF46);
    rd(8'hFC, 32'h0);
    wr(OFS_FORMAT, 32'h30);
    rd(OFS_FORMAT, 32'h7);
    wr(OFS_FORMAT, 32'h10);
    rd(OFS_FORMAT, 32'h10);
    chk({10'h0, roi_left, roi_top}, {10'h0, 11'h280, 11'h1E0});
    chk({10'h0, roi_width, roi_height}, {10'h0, 11'h140, 11'h0F0});
    wr(OFS_CONTROL, 32'h1);
    px_chk(2'h2);
    for (int i = 0; i < 5; i++) begin
      wr(OFS_RATE, 32'(i));
      rd(OFS_RATE, 32'(i));
      per(200 << (4 - i));
    end
    wr(OFS_FORMAT, 32'h52);
    rd(OFS_FORMAT, 32'h10);
    wr(OFS_RATE, 32'h2);
    for (int i = 0; i < 8; i++) begin
      wr(OFS_FORMAT, {24'h0, fv[i]});
      rd(OFS_FORMAT, {24'h0, fv[i]});
      chk({21'h0, roi_width}, {21'h0, wv[i]});
    end
    slow <= 1'b1;
    px_chk(2'h1);
    wr(OFS_FORMAT, 32'h7);
    wr(OFS_BPP, 32'hF46);
    wait_calc;
    per(983 * 4);
    px_chk(2'h1);
    wr(OFS_FORMAT, 32'h52);
    px_chk(2'h0);
    rst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    rd(OFS_FORMAT, 32'h7);
    rd(OFS_BPP, 32'h1000);
    end_sim;
  end
endmodule // test_mono_video_format_selector
